//--- hw/cie_core.sv
`include "cie_defines.svh"

module cie_core (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // instruction stream
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  file_rdata,
  input  wire logic [12:0] stack_top,
  input  wire logic [4:3]  upper_pc_latch,
  input  wire logic        carry_in,
  // register file write
  output logic             file_we_ff,
  output logic [6:0]       file_waddr_ff,
  output logic [7:0]       file_wdata_ff,
  // core state
  output logic [7:0]       acc_ff,
  output logic             zero_we_ff,
  output logic             zero_ff,
  output logic             carry_we_ff,
  output logic             carry_ff,
  // control effects
  output logic             pc_load_ff,
  output logic [12:0]      pc_ff,
  output logic             stack_pop_ff,
  output logic             global_irq_enable_set_ff,
  output logic             wdt_clear_ff,
  output logic             timeout_flag_n_ff,
  output logic             powerdown_flag_n_ff,
  output logic             flush_ff
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  cie_dec_if dif ();
  cie_pkg::cie_state_e state_ff;
  logic [13:0] word;

  // a flushed slot executes as a no-op whatever was prefetched
  assign word = (state_ff == cie_pkg::CIE_ST_FLUSH) ? `CIE_NOP_WORD : instr;
  assign dif.word = word;

  cie_field_dec u_dec (
    .d (dif.dec)
  );

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  logic [7:0] res;
  logic       wr_en;
  logic       z_en;
  logic       c_en;
  logic       c_new;
  logic       skip;
  logic       acc_en;
  logic [7:0] acc_new;

  always_comb begin
    res     = 8'h00;
    wr_en   = 1'b0;
    z_en    = 1'b0;
    c_en    = 1'b0;
    c_new   = carry_in;
    skip    = 1'b0;
    acc_en  = 1'b0;
    acc_new = acc_ff;
    if (dif.is_file) begin
      unique case (dif.fop)
        `CIE_F_STORE: begin
          res   = acc_ff;
          wr_en = dif.word[7];
        end
        `CIE_F_COM: begin
          res   = ~file_rdata;
          wr_en = 1'b1;
          z_en  = 1'b1;
        end
        `CIE_F_DEC: begin
          res   = file_rdata - 8'h01;
          wr_en = 1'b1;
          z_en  = 1'b1;
        end
        `CIE_F_INC: begin
          res   = file_rdata + 8'h01;
          wr_en = 1'b1;
          z_en  = 1'b1;
        end
        `CIE_F_DECSZ: begin
          res   = file_rdata - 8'h01;
          wr_en = 1'b1;
          skip  = (res == 8'h00);
        end
        `CIE_F_INCSZ: begin
          res   = file_rdata + 8'h01;
          wr_en = 1'b1;
          skip  = (res == 8'h00);
        end
        `CIE_F_OR: begin
          res   = acc_ff | file_rdata;
          wr_en = 1'b1;
          z_en  = 1'b1;
        end
        `CIE_F_MOV: begin
          res   = file_rdata;
          wr_en = 1'b1;
          z_en  = 1'b1;
        end
        `CIE_F_RRC: begin
          res   = {carry_in, file_rdata[7:1]};
          wr_en = 1'b1;
          c_en  = 1'b1;
          c_new = file_rdata[0];
        end
        default: ;
      endcase
      // store-acc writes the file only when bit 7 is set and never the accumulator; others obey the dest bit
      if (wr_en && dif.fop != `CIE_F_STORE && !dif.dest_f) begin
        acc_en  = 1'b1;
        acc_new = res;
      end
    end else if (dif.is_lit) begin
      if (dif.word[11:10] == `CIE_L_LOAD ||
          dif.word[11:10] == `CIE_L_RET) begin
        acc_en  = 1'b1;
        acc_new = dif.lit;
      end else if (dif.fop == `CIE_L_OR) begin
        acc_en  = 1'b1;
        acc_new = acc_ff | dif.lit;
        res     = acc_new;
        z_en    = 1'b1;
      end
    end
  end

  logic is_ret;
  logic is_kick;
  logic is_reti;
  assign is_kick = (word == `CIE_OP_KICK_WDT);
  assign is_reti = (word == `CIE_OP_RET_IRQ);
  assign is_ret  = is_reti || (word == `CIE_OP_RET_SUB) ||
                   (dif.is_lit && dif.word[11:10] == `CIE_L_RET);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= cie_pkg::CIE_ST_EXEC;
    end else if (state_ff == cie_pkg::CIE_ST_FLUSH) begin
      state_ff <= cie_pkg::CIE_ST_EXEC;
    end else if (skip || dif.is_jmp || is_ret) begin
      state_ff <= cie_pkg::CIE_ST_FLUSH;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      file_we_ff    <= 1'b0;
      file_waddr_ff <= 7'h00;
      file_wdata_ff <= 8'h00;
    end else begin
      file_we_ff    <= wr_en && (dif.dest_f || dif.fop == `CIE_F_STORE);
      file_waddr_ff <= dif.faddr;
      file_wdata_ff <= res;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_ff <= `CIE_ACC_RST;
    end else if (acc_en) begin
      acc_ff <= acc_new;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      zero_we_ff  <= 1'b0;
      zero_ff     <= 1'b0;
      carry_we_ff <= 1'b0;
      carry_ff    <= 1'b0;
    end else begin
      zero_we_ff  <= z_en;
      if (z_en) zero_ff <= (res == 8'h00);
      carry_we_ff <= c_en;
      if (c_en) carry_ff <= c_new;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_load_ff               <= 1'b0;
      pc_ff                    <= `CIE_PC_RST;
      stack_pop_ff             <= 1'b0;
      global_irq_enable_set_ff <= 1'b0;
    end else begin
      pc_load_ff   <= dif.is_jmp || is_ret;
      stack_pop_ff <= is_ret;
      global_irq_enable_set_ff <= is_reti;
      if (dif.is_jmp) begin
        pc_ff <= {upper_pc_latch, dif.jaddr};
      end else if (is_ret) begin
        pc_ff <= stack_top;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdt_clear_ff        <= 1'b0;
      timeout_flag_n_ff   <= 1'b1;
      powerdown_flag_n_ff <= 1'b1;
    end else begin
      wdt_clear_ff <= is_kick;
      if (is_kick) begin
        timeout_flag_n_ff   <= 1'b1;
        powerdown_flag_n_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) flush_ff <= 1'b0;
    else     flush_ff <= (state_ff == cie_pkg::CIE_ST_EXEC) &&
                         (skip || dif.is_jmp || is_ret);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_kick;
    @(posedge clk_sys) disable iff (rst)
    (is_kick) |=> (wdt_clear_ff && timeout_flag_n_ff && powerdown_flag_n_ff);
  endproperty
  a_kick: assert property (p_kick) else $error("kick missing");
  property p_skip;
    @(posedge clk_sys) disable iff (rst)
    (skip && state_ff == cie_pkg::CIE_ST_EXEC) |=>
      (state_ff == cie_pkg::CIE_ST_FLUSH && !zero_we_ff) ##1
      (state_ff == cie_pkg::CIE_ST_EXEC);
  endproperty
  a_skip: assert property (p_skip) else $error("skip length");
  property p_jump;
    @(posedge clk_sys) disable iff (rst)
    (dif.is_jmp) |=> (pc_load_ff && pc_ff == {$past(upper_pc_latch),
                      $past(dif.jaddr)});
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");
  property p_ret;
    @(posedge clk_sys) disable iff (rst)
    (is_ret) |=> (stack_pop_ff && pc_ff == $past(stack_top) && !zero_we_ff);
  endproperty
  a_ret: assert property (p_ret) else $error("return pop");
  property p_reti;
    @(posedge clk_sys) disable iff (rst)
    global_irq_enable_set_ff |-> $past(is_reti);
  endproperty
  a_reti: assert property (p_reti) else $error("irq enable");
  property p_dest;
    @(posedge clk_sys) disable iff (rst)
    (wr_en && dif.fop != `CIE_F_STORE && !dif.dest_f) |=>
      (!file_we_ff && acc_ff == $past(res));
  endproperty
  a_dest: assert property (p_dest) else $error("dest route");
  property p_invert;
    @(posedge clk_sys) disable iff (rst)
    (dif.is_file && dif.fop == `CIE_F_COM) |=>
      (zero_we_ff && zero_ff == ($past(file_rdata) == 8'hff));
  endproperty
  a_invert: assert property (p_invert) else $error("zero flag");
  property p_rot;
    @(posedge clk_sys) disable iff (rst)
    (dif.is_file && dif.fop == `CIE_F_RRC) |=>
      (carry_ff == $past(file_rdata[0]) &&
       file_wdata_ff[7] == $past(carry_in));
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");
endmodule // cie_core

//--- hw/cie_dec_if.sv
interface cie_dec_if;
  logic [13:0] word;
  logic        is_file;
  logic        is_lit;
  logic        is_jmp;
  logic [3:0]  fop;
  logic        dest_f;
  logic [6:0]  faddr;
  logic [7:0]  lit;
  logic [10:0] jaddr;
  modport dec (input word, output is_file, is_lit, is_jmp, fop, dest_f,
               faddr, lit, jaddr);
  modport use_side (output word, input is_file, is_lit, is_jmp, fop,
                    dest_f, faddr, lit, jaddr);
endinterface

//--- hw/cie_defines.svh
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH

// ----------------------------------------------------------------
// opcode patterns (14-bit words)
// ----------------------------------------------------------------
`define CIE_OP_KICK_WDT   14'h0064
`define CIE_OP_RET_IRQ    14'h0009
`define CIE_OP_RET_SUB    14'h0008
`define CIE_NOP_WORD      14'h0000

// byte-oriented sub-opcodes, bits 11:8
`define CIE_F_STORE       4'h0
`define CIE_F_DEC         4'h3
`define CIE_F_OR          4'h4
`define CIE_F_MOV         4'h8
`define CIE_F_COM         4'h9
`define CIE_F_INC         4'ha
`define CIE_F_DECSZ       4'hb
`define CIE_F_RRC         4'hc
`define CIE_F_INCSZ       4'hf

// literal class sub-opcodes, bits 11:10 or 11:8
`define CIE_L_LOAD        2'h0
`define CIE_L_RET         2'h1
`define CIE_L_OR          4'h8

// field positions
`define CIE_DEST_BIT      7
`define CIE_IRQ_EN_BIT    7
`define CIE_JMP_BIT       11

// reset values
`define CIE_ACC_RST       8'h00
`define CIE_PC_RST        13'h0000

`endif

//--- hw/cie_field_dec.sv
`include "cie_defines.svh"

module cie_field_dec (
  cie_dec_if.dec d
);
  cie_pkg::cie_class_e cls;
  assign cls       = cie_pkg::cie_class_e'(d.word[13:12]);
  assign d.is_file = (cls == cie_pkg::CIE_CLS_FILE);
  assign d.is_lit  = (cls == cie_pkg::CIE_CLS_LIT);
  assign d.is_jmp  = (cls == cie_pkg::CIE_CLS_JMP) &&
                     d.word[`CIE_JMP_BIT];
  assign d.fop     = d.word[11:8];
  assign d.dest_f  = d.word[`CIE_DEST_BIT];
  assign d.faddr   = d.word[6:0];
  assign d.lit     = d.word[7:0];
  assign d.jaddr   = d.word[10:0];
endmodule // cie_field_dec

//--- hw/cie_pkg.sv
package cie_pkg;
  typedef enum logic [1:0] {
    CIE_CLS_FILE = 2'b00,
    CIE_CLS_BIT  = 2'b01,
    CIE_CLS_JMP  = 2'b10,
    CIE_CLS_LIT  = 2'b11
  } cie_class_e;

  typedef enum logic [1:0] {
    CIE_ST_EXEC  = 2'b00,
    CIE_ST_FLUSH = 2'b01
  } cie_state_e;
endpackage

//--- test/cie_core_bench.sv
`include "cie_defines.svh"

module cie_core_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk_sys        = 1'b0;
  logic        rst            = 1'b1;
  logic [13:0] instr          = `CIE_NOP_WORD;
  logic [7:0]  file_rdata     = 8'h00;
  logic [12:0] stack_top      = 13'h1abc;
  logic [4:3]  upper_pc_latch = 2'b01;
  logic        carry_in       = 1'b1;
  logic        we, zwe, zf, cwe, cf, pld, pop, irq_set, wdt, ton, pdn, fl;
  logic [6:0]  waddr;
  logic [7:0]  wdata, acc;
  logic [12:0] pc;
  int          miscompares    = 0;
  int          num_checks     = 0;

  always #2.5 clk_sys = ~clk_sys;

  cie_core cie_core_inst (
    .clk_sys(clk_sys), .rst(rst), .instr(instr), .file_rdata(file_rdata),
    .stack_top(stack_top), .upper_pc_latch(upper_pc_latch),
    .carry_in(carry_in), .file_we_ff(we), .file_waddr_ff(waddr),
    .file_wdata_ff(wdata), .acc_ff(acc), .zero_we_ff(zwe), .zero_ff(zf),
    .carry_we_ff(cwe), .carry_ff(cf), .pc_load_ff(pld), .pc_ff(pc),
    .stack_pop_ff(pop), .global_irq_enable_set_ff(irq_set),
    .wdt_clear_ff(wdt), .timeout_flag_n_ff(ton),
    .powerdown_flag_n_ff(pdn), .flush_ff(fl)
  );

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  // outputs seen after a step belong to the word of the step before
  task automatic step(input logic [13:0] w, input logic [7:0] r);
    @(posedge clk_sys);
    instr <= w;
    file_rdata <= r;
    #1;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [13:0] fw(logic [3:0] op, logic d, logic [6:0] f);
    return {2'b00, op, d, f};
  endfunction

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_kick();
    step(`CIE_OP_KICK_WDT, 8'h00);
    chk("acc", 8'h00, acc);
    chk("pc", 13'h0000, pc);
    chk("we", 1'b0, we);
    step(`CIE_NOP_WORD, 8'h00);
    chk("wdt", 1'b1, wdt);
    chk("timeout_flag_n", 1'b1, ton);
    chk("powerdown_flag_n", 1'b1, pdn);
    chk("we", 1'b0, we);
    step(`CIE_NOP_WORD, 8'h00);
    chk("wdt", 1'b0, wdt);
  endtask

  task automatic t_file_ops();
    logic [3:0] ops [6] = '{`CIE_F_COM, `CIE_F_DEC, `CIE_F_INC,
                            `CIE_F_MOV, `CIE_F_OR, `CIE_F_RRC};
    // operand 01, accumulator 5a, carry 1
    logic [7:0] res [6] = '{8'hfe, 8'h00, 8'h02, 8'h01, 8'h5b, 8'h80};
    for (int i = 0; i < 6; i++) begin
      for (int d = 0; d < 2; d++) begin
        step(14'h305a, 8'h00);
        step(fw(ops[i], d[0], 7'h7f), 8'h01);
        step(`CIE_NOP_WORD, 8'h00);
        chk("acc", d[0] ? 8'h5a : res[i], acc);
        chk("we", d[0], we);
        if (d[0]) begin
          chk("waddr", 7'h7f, waddr);
          chk("wdata", res[i], wdata);
        end
        if (i == 5) begin
          chk("cwe", 1'b1, cwe);
          chk("carry", 1'b1, cf);
          chk("zwe", 1'b0, zwe);
        end else begin
          chk("zwe", 1'b1, zwe);
          chk("zero", res[i] == 8'h00, zf);
        end
      end
    end
    // a clear carry must reach bit 7, else a stuck carry would pass
    @(posedge clk_sys);
    carry_in   <= 1'b0;
    instr      <= fw(`CIE_F_RRC, 1'b1, 7'h22);
    file_rdata <= 8'h02;
    #1;
    step(`CIE_NOP_WORD, 8'h00);
    chk("wdata", 8'h01, wdata);
    chk("carry", 1'b0, cf);
  endtask

  task automatic t_skip();
    step(14'h305a, 8'h00);
    step(fw(`CIE_F_DECSZ, 1'b1, 7'h05), 8'h01);
    step(14'h3033, 8'h00);
    chk("wdata", 8'h00, wdata);
    chk("flush", 1'b1, fl);
    chk("zwe", 1'b0, zwe);
    step(`CIE_NOP_WORD, 8'h00);
    chk("acc", 8'h5a, acc);
    step(fw(`CIE_F_INCSZ, 1'b0, 7'h05), 8'h05);
    step(`CIE_NOP_WORD, 8'h00);
    chk("acc", 8'h06, acc);
    chk("flush", 1'b0, fl);
    step(fw(`CIE_F_INCSZ, 1'b0, 7'h05), 8'hff);
    step(`CIE_NOP_WORD, 8'h00);
    chk("acc", 8'h00, acc);
    chk("flush", 1'b1, fl);
    chk("zwe", 1'b0, zwe);
  endtask

  task automatic t_jump();
    step(14'h2fff, 8'h00);
    step(14'h3033, 8'h00);
    chk("pld", 1'b1, pld);
    chk("pc", 13'h0fff, pc);
    chk("flush", 1'b1, fl);
    // the latch moves on the edge that runs the flushed slot
    @(posedge clk_sys);
    upper_pc_latch <= 2'b10;
    instr          <= 14'h2800;
    #1;
    step(`CIE_NOP_WORD, 8'h00);
    chk("pc", 13'h1000, pc);
    chk("acc", 8'h00, acc);
  endtask

  task automatic t_returns();
    logic [13:0] w [3] = '{`CIE_OP_RET_SUB, `CIE_OP_RET_IRQ, 14'h37a5};
    for (int i = 0; i < 3; i++) begin
      step(w[i], 8'h00);
      step(`CIE_NOP_WORD, 8'h00);
      chk("pc", 13'h1abc, pc);
      chk("pop", 1'b1, pop);
      chk("flush", 1'b1, fl);
      chk("irq_set", i == 1, irq_set);
      chk("zwe", 1'b0, zwe);
    end
    chk("acc", 8'ha5, acc);
  endtask

  task automatic t_literals();
    step(14'h3300, 8'h00);
    step(14'h3800, 8'h00);
    chk("acc", 8'h00, acc);
    chk("zwe", 1'b0, zwe);
    step(14'h3881, 8'h00);
    chk("zero", 1'b1, zf);
    step(14'h0091, 8'h00);
    chk("acc", 8'h81, acc);
    chk("zero", 1'b0, zf);
    step(`CIE_NOP_WORD, 8'h00);
    chk("we", 1'b1, we);
    chk("waddr", 7'h11, waddr);
    chk("wdata", 8'h81, wdata);
    chk("zwe", 1'b0, zwe);
    step(`CIE_NOP_WORD, 8'h00);
    chk("we", 1'b0, we);
    chk("acc", 8'h81, acc);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_kick();
    t_file_ops();
    t_skip();
    t_jump();
    t_returns();
    t_literals();
    give_verdict();
  end

  // bounded run: a stall ends in the same report
  initial begin
    repeat (2000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end
endmodule // cie_core_bench
